// *** design/dpram_host_pkg.sv ***
package dpram_host_pkg;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 9;
	localparam int CLK_PERIOD_NS = 10;
	// timing figures in ns
	localparam int READ_CYCLE_PERIOD_NS = 15;
	localparam int WRITE_PULSE_WIDTH_NS = 12;
	localparam int OUT_OFF_NS = 10;
	localparam int DATA_SETUP_NS = 10;
	localparam int TOKEN_WRITE_TO_READ_TIME_NS = 5;
	localparam int TOKEN_UPDATE_PULSE_NS = 10;
	localparam int ACCESS_NS = 15;
	// cycle counts: least times round up
	localparam int POWERUP_CYC = (READ_CYCLE_PERIOD_NS + CLK_PERIOD_NS) / CLK_PERIOD_NS;
	localparam int WP_CYC = (WRITE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WP_OE_CYC = (OUT_OFF_NS + DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SWRD_CYC = (TOKEN_WRITE_TO_READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SOP_CYC = (TOKEN_UPDATE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACC_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;

	typedef enum logic [2:0] {
		ST_POWERUP = 3'h0,
		ST_IDLE    = 3'h1,
		ST_SETUP   = 3'h2,
		ST_STROBE  = 3'h3,
		ST_READ    = 3'h4,
		ST_GAP     = 3'h5
	} state_t;

	typedef struct packed {
		logic              valid;
		logic              write;
		logic              token;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} req_t;

	typedef struct packed {
		logic              select_n;
		logic              token_flag_select_n;
		logic              write_n;
		logic              out_en_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_o;
		logic              dq_oe_n;
	} pins_t;

	typedef struct packed {
		state_t            st;
		logic [CNT_W-1:0]  cnt;
		req_t              cur;
		pins_t             pins;
		logic              ready;
		logic              done;
		logic [DATA_W-1:0] rdata;
		logic              busy_seen;
		logic              busy_s1;
		logic              busy_s2;
		logic [DATA_W-1:0] dq_s1;
		logic [DATA_W-1:0] dq_s2;
	} regs_t;
endpackage : dpram_host_pkg

// *** design/dpram_host.sv ***
`timescale 1ns/1ns
// How it works
// - strobe high whenever address changes
// - pulse covers output off plus data setup when output enable low (2 cycles, same as plain pulse)
// - never drive data while memory drives
// - token readback keeps select high, waits
// - pulse token select high between accesses
// - select held high in retention once any access already under way has ended
// - wait past one read cycle after power
module dpram_host (
	// clock and reset
	input  wire logic                                clk_i,
	input  wire logic                                rst_n_i,
	// user request side
	input  wire dpram_host_pkg::req_t                req_i,
	input  wire logic                                retain_i,
	input  wire logic                                out_en_write_i,
	output logic                                     ready_o,
	output logic                                     done_o,
	output logic [dpram_host_pkg::DATA_W-1:0]        rdata_o,
	output logic                                     busy_seen_o,
	// memory port pins
	output dpram_host_pkg::pins_t                    pins_o,
	input  wire logic [dpram_host_pkg::DATA_W-1:0]   dq_i,
	input  wire logic                                busy_n_i
);
	dpram_host_pkg::regs_t r;
	dpram_host_pkg::regs_t next_r;
	logic [dpram_host_pkg::CNT_W-1:0] wp_len;

	always_comb begin
		wp_len = out_en_write_i ? dpram_host_pkg::CNT_W'(dpram_host_pkg::WP_OE_CYC)
		                        : dpram_host_pkg::CNT_W'(dpram_host_pkg::WP_CYC);
		next_r = r;
		next_r.busy_s1 = ~busy_n_i;
		next_r.busy_s2 = r.busy_s1;
		next_r.dq_s1 = dq_i;
		next_r.dq_s2 = r.dq_s1;
		next_r.done = 1'b0;
		if (r.cnt != '0)
			next_r.cnt = r.cnt - 1'b1;
		case (r.st)
			dpram_host_pkg::ST_POWERUP: begin
				if (r.cnt == '0) begin
					next_r.st = dpram_host_pkg::ST_IDLE;
					next_r.ready = ~retain_i;
				end
			end
			dpram_host_pkg::ST_IDLE: begin
				next_r.ready = ~retain_i;
				next_r.pins.select_n = 1'b1;
				next_r.pins.token_flag_select_n = 1'b1;
				next_r.pins.write_n = 1'b1;
				next_r.pins.out_en_n = 1'b1;
				next_r.pins.dq_oe_n = 1'b1;
				if (req_i.valid && r.ready && !retain_i) begin
					next_r.ready = 1'b0;
					next_r.cur = req_i;
					next_r.busy_seen = 1'b0;
					// address moves only while strobe is high
					next_r.pins.addr = req_i.addr;
					next_r.st = dpram_host_pkg::ST_SETUP;
				end
			end
			dpram_host_pkg::ST_SETUP: begin
				// select first, strobe next cycle
				if (r.cur.token)
					next_r.pins.token_flag_select_n = 1'b0;
				else
					next_r.pins.select_n = 1'b0;
				if (r.cur.write) begin
					next_r.pins.out_en_n = ~out_en_write_i;
					next_r.st = dpram_host_pkg::ST_STROBE;
				end else begin
					next_r.pins.out_en_n = 1'b0;
					next_r.cnt = dpram_host_pkg::CNT_W'(dpram_host_pkg::ACC_CYC);
					next_r.st = dpram_host_pkg::ST_READ;
				end
				if (r.cur.write)
					next_r.cnt = wp_len;
			end
			dpram_host_pkg::ST_STROBE: begin
				// strobe falls a cycle after select
				next_r.pins.write_n = 1'b0;
				// data driven after memory outputs turn off
				if (!r.pins.write_n) begin
					next_r.pins.dq_oe_n = 1'b0;
					next_r.pins.dq_o = r.cur.token ? {{(dpram_host_pkg::DATA_W-1){1'b1}},
					                                  r.cur.wdata[0]} : r.cur.wdata;
				end
				if (r.busy_s2)
					next_r.busy_seen = 1'b1;
				if (r.cnt == '0) begin
					next_r.pins.write_n = 1'b1;
					next_r.pins.select_n = 1'b1;
					next_r.pins.token_flag_select_n = 1'b1;
					next_r.pins.out_en_n = 1'b1;
					next_r.cnt = dpram_host_pkg::CNT_W'(dpram_host_pkg::SOP_CYC
					             > dpram_host_pkg::SWRD_CYC ? dpram_host_pkg::SOP_CYC
					             : dpram_host_pkg::SWRD_CYC);
					next_r.st = dpram_host_pkg::ST_GAP;
				end
			end
			dpram_host_pkg::ST_READ: begin
				if (r.busy_s2)
					next_r.busy_seen = 1'b1;
				if (r.cnt == '0) begin
					// token read: bit 0 low means held by us
					next_r.rdata = r.dq_s2;
					next_r.pins.select_n = 1'b1;
					next_r.pins.token_flag_select_n = 1'b1;
					next_r.pins.out_en_n = 1'b1;
					next_r.cnt = dpram_host_pkg::CNT_W'(dpram_host_pkg::SOP_CYC);
					next_r.st = dpram_host_pkg::ST_GAP;
				end
			end
			dpram_host_pkg::ST_GAP: begin
				next_r.pins.dq_oe_n = 1'b1;
				if (r.cnt == '0) begin
					next_r.done = 1'b1;
					next_r.ready = ~retain_i;
					next_r.st = dpram_host_pkg::ST_IDLE;
				end
			end
			default: next_r.st = dpram_host_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
			r.st <= dpram_host_pkg::ST_POWERUP;
			r.cnt <= dpram_host_pkg::CNT_W'(dpram_host_pkg::POWERUP_CYC);
			r.pins.select_n <= 1'b1;
			r.pins.token_flag_select_n <= 1'b1;
			r.pins.write_n <= 1'b1;
			r.pins.out_en_n <= 1'b1;
			r.pins.dq_oe_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign ready_o = r.ready;
	assign done_o = r.done;
	assign rdata_o = r.rdata;
	assign busy_seen_o = r.busy_seen;
	assign pins_o = r.pins;

	sequence write_low_s;
		!r.pins.write_n;
	endsequence

	addr_stable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!r.pins.write_n && (!r.pins.select_n || !r.pins.token_flag_select_n))
		|=> $stable(r.pins.addr) || r.pins.write_n)
		else $error("address moved during write");
	write_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		write_low_s |-> (!r.pins.select_n || !r.pins.token_flag_select_n))
		else $error("write strobe without select");
	select_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(r.pins.write_n) |-> $past(!r.pins.select_n || !r.pins.token_flag_select_n))
		else $error("strobe fell before select");
	no_contend_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!r.pins.dq_oe_n |-> r.pins.out_en_n || !r.pins.write_n)
		else $error("data driven while memory drives");
	pulse_len_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(r.pins.write_n) |-> !r.pins.write_n [*2])
		else $error("write pulse too short");
	gap_len_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(r.pins.token_flag_select_n) |-> r.pins.token_flag_select_n [*2])
		else $error("token update pulse too short");
	one_select_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!r.pins.token_flag_select_n |-> r.pins.select_n)
		else $error("both selects low");
	retain_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(retain_i && r.st == dpram_host_pkg::ST_IDLE) |=> r.pins.select_n)
		else $error("select low in retention");
	powerup_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		r.st == dpram_host_pkg::ST_POWERUP |-> r.pins.select_n && !r.ready)
		else $error("access during power up");

	sequence sel_low_s;
		(!r.pins.select_n || !r.pins.token_flag_select_n);
	endsequence

	data_before_end_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(r.pins.write_n) |-> $past(!r.pins.dq_oe_n))
		else $error("write ended without data set up");
	strobe_end_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(r.pins.write_n) |-> r.pins.select_n && r.pins.token_flag_select_n)
		else $error("select still low after write end");
	addr_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		sel_low_s ##1 sel_low_s
		|-> $stable(r.pins.addr))
		else $error("address moved while selected");
	token_ones_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!r.pins.dq_oe_n && !r.pins.token_flag_select_n)
		|-> (&r.pins.dq_o[dpram_host_pkg::DATA_W-1:1]))
		else $error("token write data upper bits not high");
	retain_ready_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		retain_i |=> !r.ready)
		else $error("ready during retention");
	busy_note_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(r.busy_s2 && r.st == dpram_host_pkg::ST_READ) |=> r.busy_seen)
		else $error("busy not reported");
	read_no_drive_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(r.st == dpram_host_pkg::ST_READ) |-> r.pins.dq_oe_n)
		else $error("data driven during read");
	token_gap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(r.pins.token_flag_select_n) |-> r.pins.select_n [*2])
		else $error("select low around token access");
	oe_gap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(r.pins.out_en_n) |-> r.pins.out_en_n [*2])
		else $error("output enable pulse too short");
	powerup_wait_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(r.st == dpram_host_pkg::ST_POWERUP && r.cnt != '0) |=> !r.ready)
		else $error("ready before power up wait");
endmodule : dpram_host

// *** bench/dpram_model.sv ***
`timescale 1ns/1ns
module dpram_model (
	// host pins
	input  wire dpram_host_pkg::pins_t        pins_i,
	// far port
	input  wire logic                         other_hold_i,
	input  wire logic                         other_sel_i,
	// memory outputs
	output logic [dpram_host_pkg::DATA_W-1:0] dq_o,
	output logic                              busy_n_o,
	output logic                              clash_o
);
	logic [8:0] mem [16];
	logic [1:0] tok = 2'h0; // free at start
	logic [8:0] last = 9'h000;
	logic [8:0] wd;
	logic [8:0] val;
	logic       cs;
	logic       ts;
	logic       drv;
	initial clash_o = 1'b0;
	assign drv = !pins_i.out_en_n && pins_i.write_n
		&& (!pins_i.select_n || !pins_i.token_flag_select_n);
	assign val = !pins_i.select_n ? mem[pins_i.addr[3:0]] : {8'hFF, tok != 2'h1};
	assign dq_o = drv ? val : ~last;
	assign busy_n_o = !(!pins_i.select_n && other_sel_i && pins_i.addr == 15'h0005);
	always @* if (drv) last = val;
	always @* if (drv && !pins_i.dq_oe_n) clash_o = 1'b1;
	always @(pins_i) if (!pins_i.write_n) begin
		wd = pins_i.dq_o;
		cs = !pins_i.select_n;
		ts = !pins_i.token_flag_select_n;
	end
	always @(posedge pins_i.write_n) begin
		if (cs) mem[pins_i.addr[3:0]] <= wd;
		else if (ts && !wd[0] && tok == 2'h0) tok <= 2'h1;
		else if (ts && wd[0] && tok == 2'h1) tok <= other_hold_i ? 2'h2 : 2'h0;
	end
	always @(posedge other_hold_i) if (tok == 2'h0) tok <= 2'h2;
endmodule : dpram_model

// *** bench/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
	typedef struct packed {logic w; logic t; logic oe; logic [14:0] a; logic [8:0] d;} row_t;
	logic                  clk_i = 1'h0;
	logic                  rst_n_i = 1'h0;
	dpram_host_pkg::req_t  req_i = '0;
	logic                  retain_i = 1'h0;
	logic                  oe_w = 1'h0;
	logic                  hold = 1'h0;
	logic                  osel = 1'h0;
	logic                  ready_o;
	logic                  done_o;
	logic                  busy_seen_o;
	logic                  clash;
	logic                  busy_n;
	logic [8:0]            rdata_o;
	logic [8:0]            dq;
	dpram_host_pkg::pins_t pins_o;
	int                    fail_count = 0;
	int                    tests_run = 0;
	row_t rows [8] = '{'{1'h1, 1'h0, 1'h0, 15'h0005, 9'h1A5}, '{1'h1, 1'h0, 1'h1, 15'h0006, 9'h05A},
		'{1'h0, 1'h0, 1'h0, 15'h0005, 9'h1A5}, '{1'h0, 1'h0, 1'h0, 15'h0006, 9'h05A},
		'{1'h1, 1'h1, 1'h0, 15'h0000, 9'h000}, '{1'h0, 1'h1, 1'h0, 15'h0000, 9'h1FE},
		'{1'h1, 1'h1, 1'h0, 15'h0000, 9'h001}, '{1'h0, 1'h1, 1'h0, 15'h0000, 9'h1FF}};
	dpram_host u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .retain_i(retain_i),
		.out_en_write_i(oe_w), .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o),
		.busy_seen_o(busy_seen_o), .pins_o(pins_o), .dq_i(dq), .busy_n_i(busy_n));
	dpram_model u_mem (.pins_i(pins_o), .other_hold_i(hold), .other_sel_i(osel), .dq_o(dq),
		.busy_n_o(busy_n), .clash_o(clash));
	initial forever #5 clk_i = ~clk_i;
	task automatic print_verdict();
		$display("mismatches %0d of %0d checks", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic access(input row_t r);
		int n;
		n = 0;
		while (ready_o !== 1'h1 && n < 50) begin
			@(negedge clk_i);
			n++;
		end
		@(posedge clk_i) req_i <= '{1'h1, r.w, r.t, r.a, r.d};
		oe_w <= r.oe;
		@(posedge clk_i) req_i.valid <= 1'h0;
		n = 0;
		while (done_o !== 1'h1 && n < 50) begin
			@(negedge clk_i);
			n++;
		end
		check(9'(n < 50), 9'h001);
		if (!r.w) check(rdata_o, r.d);
	endtask : access
	task automatic reset_cycle();
		rst_n_i <= 1'h0;
		repeat (8) @(posedge clk_i);
		check(9'(pins_o.select_n), 9'h001);
		check(9'(pins_o.dq_oe_n), 9'h001);
		rst_n_i <= 1'h1;
		@(negedge clk_i) check(9'(ready_o), 9'h000);
	endtask : reset_cycle
	initial begin
		#200000;
		fail_count++;
		print_verdict();
	end
	initial begin
		reset_cycle();
		foreach (rows[i]) access(rows[i]);
		hold <= 1'h1;
		access(rows[4]);
		access(rows[7]);
		osel <= 1'h1;
		access(rows[2]);
		check(9'(busy_seen_o), 9'h001);
		osel <= 1'h0;
		access(rows[3]);
		check(9'(busy_seen_o), 9'h000);
		@(posedge clk_i) retain_i <= 1'h1;
		req_i.valid <= 1'h1;
		repeat (12) @(negedge clk_i) check(9'(pins_o.select_n), 9'h001);
		@(posedge clk_i) req_i.valid <= 1'h0;
		@(posedge clk_i) retain_i <= 1'h0;
		check(9'(clash), 9'h000);
		reset_cycle();
		access(rows[2]);
		print_verdict();
	end
endmodule : tb_top
